// ==== hw/uee_pkg.sv ====
package uee_pkg;
  // ------------------------------------------------------------
  // status bit positions, reset values, sizes and receiver states
  // ------------------------------------------------------------
  localparam int unsigned FRAMING_BIT = 6;
  localparam int unsigned PARITY_BIT = 5;
  localparam int unsigned OVERRUN_BIT = 4;
  localparam logic PORT_ENABLE_RESET = 1'b0;
  localparam logic FLAG_RESET = 1'b0;
  localparam int unsigned DATA_BITS = 8;
  localparam int unsigned BAUD_DIV = 16;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  typedef enum {
    UEE_IDLE,
    UEE_START,
    UEE_DATA,
    UEE_PARITY,
    UEE_STOP
  } uee_state_t;
endpackage

// ==== hw/uee_skid.sv ====
module uee_skid #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  // ------------------------------------------------------------
  // two-entry buffer
  // ------------------------------------------------------------
  logic [WIDTH-1:0] mem [2];
  logic [1:0] count;
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] next_count;
  logic next_wr_ptr;
  logic next_rd_ptr;
  logic push;
  logic pop;

  assign in_ready = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data = mem[rd_ptr];

  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_count = count;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    if (flush) begin
      next_count = 2'h0;
      next_wr_ptr = 1'b0;
      next_rd_ptr = 1'b0;
    end else begin
      if (push) begin
        next_wr_ptr = ~wr_ptr;
      end
      if (pop) begin
        next_rd_ptr = ~rd_ptr;
      end
      if (push && !pop) begin
        next_count = count + 2'h1;
      end else if (pop && !push) begin
        next_count = count - 2'h1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      count <= 2'h0;
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
    end else begin
      count <= next_count;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
    if (push && !flush) begin
      mem[wr_ptr] <= in_data;
    end
  end

  chk_skid_bound: assert property (@(posedge ref_clk) disable iff (!rst_b)
    count <= 2'h2) else $error("skid buffer over count");
endmodule // uee_skid

// ==== hw/uee_top.sv ====
// Behaviour
// - transfers only while port enabled, reset 0
// - disable stops transfers, flushes both buffers
// - character in flight on disable undefined
// - error flags read 1 on error, reset 0
// - framing flag bit6 on zero stop bit
// - parity checked when enabled, flag bit5
// - overrun flag bit4 when buffer still full
// - overrun keeps buffer, shift register overwritten
// - flags clear by write one or disable
// - external clock option, dedicated data pins
module uee_top #(
  parameter int unsigned DIV = uee_pkg::BAUD_DIV
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic port_enable,
  input wire logic parity_check_enable,
  input wire logic parity_odd,
  input wire logic ext_clk_select,
  input wire logic ext_clk_pin,
  input wire logic [7:0] status_clear,
  output logic [7:0] status,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic rx_read,
  output logic serial_tx_pin,
  input wire logic serial_rx_pin
);
  // ------------------------------------------------------------
  // bit tick: internal divider or external clock edge
  // ------------------------------------------------------------
  logic [7:0] div_cnt, next_div_cnt;
  logic ext_q, next_ext_q;
  logic tick;
  logic flush;

  assign flush = !port_enable;

  always_comb begin
    next_ext_q = ext_clk_pin;
    next_div_cnt = div_cnt + 8'h01;
    if (flush || div_cnt == 8'(DIV - 1)) begin
      next_div_cnt = 8'h00;
    end
    tick = ext_clk_select ? (ext_clk_pin && !ext_q)
                          : (div_cnt == 8'(DIV - 1));
    tick = tick && port_enable;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      div_cnt <= 8'h00;
      ext_q <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      ext_q <= next_ext_q;
    end
  end

  // ------------------------------------------------------------
  // transmit path through two-entry buffer
  // ------------------------------------------------------------
  logic txb_valid, txb_take;
  logic [7:0] txb_data;

  uee_skid #(.WIDTH(8)) u_tx_buf (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .flush(flush),
    .in_valid(tx_valid && port_enable),
    .in_ready(tx_ready),
    .in_data(tx_data),
    .out_valid(txb_valid),
    .out_ready(txb_take),
    .out_data(txb_data)
  );

  logic [9:0] tx_sh, next_tx_sh;
  logic [3:0] tx_bits, next_tx_bits;

  always_comb begin
    next_tx_sh = tx_sh;
    next_tx_bits = tx_bits;
    txb_take = 1'b0;
    if (flush) begin
      next_tx_bits = 4'h0;
      next_tx_sh = 10'h3FF;
    end else if (tick) begin
      if (tx_bits != 4'h0) begin
        next_tx_sh = {1'b1, tx_sh[9:1]};
        next_tx_bits = tx_bits - 4'h1;
      end else if (txb_valid) begin
        txb_take = 1'b1;
        next_tx_sh = {1'b1, txb_data, 1'b0};
        next_tx_bits = 4'hA;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      tx_sh <= 10'h3FF;
      tx_bits <= 4'h0;
      serial_tx_pin <= 1'b1;
    end else begin
      tx_sh <= next_tx_sh;
      tx_bits <= next_tx_bits;
      serial_tx_pin <= (next_tx_bits != 4'h0) ? next_tx_sh[0] : 1'b1;
    end
  end

  // ------------------------------------------------------------
  // receive shift register
  // ------------------------------------------------------------
  uee_pkg::uee_state_t st, next_st;
  logic [7:0] rx_sh, next_rx_sh;
  logic [2:0] rx_idx, next_rx_idx;
  logic par_bit, next_par_bit;
  logic done;
  logic stop_bad;

  always_comb begin
    next_st = st;
    next_rx_sh = rx_sh;
    next_rx_idx = rx_idx;
    next_par_bit = par_bit;
    done = 1'b0;
    stop_bad = 1'b0;
    if (flush) begin
      next_st = uee_pkg::UEE_IDLE;
    end else if (tick) begin
      case (st)
        uee_pkg::UEE_IDLE: begin
          if (!serial_rx_pin) begin
            next_st = uee_pkg::UEE_DATA;
            next_rx_idx = 3'h0;
          end
        end
        uee_pkg::UEE_DATA: begin
          next_rx_sh = {serial_rx_pin, rx_sh[7:1]};
          next_rx_idx = rx_idx + 3'h1;
          if (rx_idx == 3'h7) begin
            next_st = parity_check_enable ? uee_pkg::UEE_PARITY
                                          : uee_pkg::UEE_STOP;
          end
        end
        uee_pkg::UEE_PARITY: begin
          next_par_bit = serial_rx_pin;
          next_st = uee_pkg::UEE_STOP;
        end
        uee_pkg::UEE_STOP: begin
          done = 1'b1;
          stop_bad = !serial_rx_pin;
          next_st = uee_pkg::UEE_IDLE;
        end
        default: next_st = uee_pkg::UEE_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      st <= uee_pkg::UEE_IDLE;
      rx_sh <= 8'h00;
      rx_idx <= 3'h0;
      par_bit <= 1'b0;
    end else begin
      st <= next_st;
      rx_sh <= next_rx_sh;
      rx_idx <= next_rx_idx;
      par_bit <= next_par_bit;
    end
  end

  // ------------------------------------------------------------
  // receive buffer and error flags
  // ------------------------------------------------------------
  logic next_rx_valid;
  logic [7:0] next_rx_data;
  logic [7:0] next_status;
  logic par_bad, ovr;

  always_comb begin
    par_bad = parity_check_enable &&
              ((^rx_sh ^ par_bit) != parity_odd);
    ovr = done && rx_valid && !rx_read;
    next_rx_valid = rx_valid;
    next_rx_data = rx_data;
    next_status = status & ~status_clear;
    if (rx_read) begin
      next_rx_valid = 1'b0;
    end
    if (done && !ovr) begin
      next_rx_valid = 1'b1;
      next_rx_data = rx_sh;
      if (par_bad) begin
        next_status[uee_pkg::PARITY_BIT] = 1'b1;
      end
    end
    if (done && stop_bad) begin
      next_status[uee_pkg::FRAMING_BIT] = 1'b1;
    end
    if (ovr) begin
      next_status[uee_pkg::OVERRUN_BIT] = 1'b1;
    end
    if (flush) begin
      next_rx_valid = 1'b0;
      next_status = uee_pkg::STATUS_RESET;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
      status <= uee_pkg::STATUS_RESET;
    end else begin
      rx_valid <= next_rx_valid;
      rx_data <= next_rx_data;
      status <= next_status;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  chk_disable_flush: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    !port_enable |=> !rx_valid && status == 8'h00)
    else $error("disable did not flush");
  chk_overrun_keep: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    ovr |=> status[uee_pkg::OVERRUN_BIT] && rx_data == $past(rx_data))
    else $error("overrun changed buffer");
  chk_framing_set: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    done && stop_bad && port_enable |=> status[uee_pkg::FRAMING_BIT])
    else $error("framing flag missed");
  chk_no_tick_off: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    !port_enable |=> st == uee_pkg::UEE_IDLE && tx_bits == 4'h0)
    else $error("transfer while disabled");
  chk_parity_off: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    !parity_check_enable && !status[uee_pkg::PARITY_BIT]
      |=> !status[uee_pkg::PARITY_BIT])
    else $error("parity flag without check");
  chk_load_full: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    done && !rx_valid && port_enable |=> rx_valid && rx_data == $past(rx_sh))
    else $error("receive buffer not loaded");
  chk_flag_sticky: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    status[uee_pkg::OVERRUN_BIT] && port_enable
      && !status_clear[uee_pkg::OVERRUN_BIT] |=> status[uee_pkg::OVERRUN_BIT])
    else $error("flag lost without clear");
  chk_tx_idle: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    !port_enable |=> serial_tx_pin)
    else $error("line not idle when disabled");
endmodule // uee_top

// ==== bench/uee_remote.sv ====
module uee_remote #(
  parameter int unsigned DIV = 2
) (
  input wire logic ref_clk,
  input wire logic serial_tx_pin,
  output logic serial_rx_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // line released high between frames
  initial serial_rx_pin = 1'b1;
  task automatic send(input logic [7:0] d, input logic pe, input logic pb,
                      input logic stop);
    int n;
    n = pe ? 11 : 10;
    @(posedge ref_clk);
    for (int i = 0; i < n; i++) begin
      serial_rx_pin <= (i == n - 1) ? stop : (i == 0) ? 1'b0 :
                       (i < 9) ? d[i-1] : pb;
      repeat (DIV) @(posedge ref_clk);
    end
    serial_rx_pin <= 1'b1;
  endtask
  // sample off the edge, in the middle of each bit
  task automatic catch_byte(output logic [7:0] d, output logic ok);
    ok = 1'b0;
    d = 8'h00;
    #1;
    for (int w = 0; w < 200 && serial_tx_pin !== 1'b0; w++) begin
      @(posedge ref_clk) #1;
    end
    if (serial_tx_pin !== 1'b0) return;
    repeat (DIV / 2) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (DIV) @(posedge ref_clk);
      #1 d[i] = serial_tx_pin;
    end
    repeat (DIV) @(posedge ref_clk);
    #1 ok = serial_tx_pin === 1'b1;
  endtask
endmodule // uee_remote

// ==== bench/tb.sv ====
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 0, rst_b = 0, port_enable = 0, parity_check_enable = 0;
  logic parity_odd = 0, tx_valid = 0, rx_read = 0, ok, serial_tx_pin;
  logic ext_clk_select = 0, ext_clk_pin = 0, ext_run = 0;
  logic serial_rx_pin, tx_ready, rx_valid;
  logic [7:0] status_clear = 8'h00, tx_data = 8'h00, status, rx_data, got;
  int err_total = 0, samples_checked = 0, cycles = 0, stalls = 0;
  always #12.5 ref_clk = ~ref_clk;
  // external bit clock: one rising edge every two cycles while running
  always @(posedge ref_clk) ext_clk_pin <= ext_run && !ext_clk_pin;
  uee_top #(.DIV(2)) uee_top_inst (.ref_clk(ref_clk), .rst_b(rst_b),
    .port_enable(port_enable), .parity_check_enable(parity_check_enable),
    .parity_odd(parity_odd), .ext_clk_select(ext_clk_select),
    .ext_clk_pin(ext_clk_pin),
    .status_clear(status_clear), .status(status), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_read(rx_read), .serial_tx_pin(serial_tx_pin),
    .serial_rx_pin(serial_rx_pin));
  uee_remote #(.DIV(2)) uee_remote_inst (.ref_clk(ref_clk),
    .serial_tx_pin(serial_tx_pin), .serial_rx_pin(serial_rx_pin));
  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wait_rx();
    #1;
    for (int n = 0; n < 40 && rx_valid !== 1'b1; n++) begin
      @(posedge ref_clk) #1;
    end
    check("rx valid", {7'h00, rx_valid}, 8'h01);
  endtask
  task automatic rd();
    @(posedge ref_clk) rx_read <= 1'b1;
    @(posedge ref_clk) rx_read <= 1'b0;
    #1;
  endtask
  task automatic clr(logic [7:0] m);
    @(posedge ref_clk) status_clear <= m;
    @(posedge ref_clk) status_clear <= 8'h00;
    #1;
  endtask
  task automatic push3(logic [23:0] w);
    @(posedge ref_clk);
    for (int i = 0; i < 3; i++) begin
      tx_valid <= 1'b1;
      tx_data <= w[8*i+:8];
      // ready is settled mid-cycle; hold the word until an edge takes it
      @(negedge ref_clk);
      for (int n = 0; n < 60 && tx_ready !== 1'b1; n++) begin
        stalls++;
        @(negedge ref_clk);
      end
      @(posedge ref_clk);
    end
    tx_valid <= 1'b0;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 8000) begin
      err_total++;
      conclude();
    end
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk) #1;
    check("status", status, 8'h00);
    check("pin", {7'h00, serial_tx_pin}, 8'h01);
    uee_remote_inst.send(8'h5A, 0, 0, 1);
    repeat (6) @(posedge ref_clk) #1;
    check("rx off", {7'h00, rx_valid}, 8'h00);
    @(posedge ref_clk) port_enable <= 1'b1;
    uee_remote_inst.send(8'hA5, 0, 0, 1);
    wait_rx();
    check("rx", rx_data, 8'hA5);
    check("status", status, 8'h00);
    rd();
    check("rx empty", {7'h00, rx_valid}, 8'h00);
    uee_remote_inst.send(8'h3C, 0, 0, 0);
    wait_rx();
    check("framing", status, 8'h40);
    clr(8'h00);
    check("clear 0", status, 8'h40);
    clr(8'h40);
    check("clear 1", status, 8'h00);
    rd();
    @(posedge ref_clk) parity_check_enable <= 1'b1;
    for (int p = 0; p < 4; p++) begin
      // A5 holds four ones: odd mode wants a one
      @(posedge ref_clk) parity_odd <= p[1];
      uee_remote_inst.send(8'hA5, 1, p[1] ^ p[0], 1);
      wait_rx();
      check("parity", status, p[0] ? 8'h20 : 8'h00);
      clr(8'h20);
      rd();
    end
    @(posedge ref_clk) parity_check_enable <= 1'b0;
    uee_remote_inst.send(8'h11, 0, 0, 1);
    wait_rx();
    uee_remote_inst.send(8'h22, 0, 0, 1);
    repeat (6) @(posedge ref_clk) #1;
    check("overrun", status, 8'h10);
    check("kept", rx_data, 8'h11);
    check("tx drained", {6'h00, tx_ready, serial_tx_pin}, 8'h03);
    @(posedge ref_clk) port_enable <= 1'b0;
    repeat (2) @(posedge ref_clk) #1;
    check("flush", {status[7:1], rx_valid}, 8'h00);
    fork
      uee_remote_inst.catch_byte(got, ok);
      begin
        @(posedge ref_clk) tx_valid <= 1'b1;
        repeat (30) @(posedge ref_clk);
        tx_valid <= 1'b0;
      end
    join
    check("tx off", {7'h00, ok}, 8'h00);
    @(posedge ref_clk) port_enable <= 1'b1;
    fork
      push3(24'h5A_C3_81);
      for (int i = 0; i < 3; i++) begin
        uee_remote_inst.catch_byte(got, ok);
        check("tx ok", {7'h00, ok}, 8'h01);
        check("tx", got, i == 0 ? 8'h81 : i == 1 ? 8'hC3 : 8'h5A);
      end
    join
    check("stall", {7'h00, stalls > 0}, 8'h01);
    // external clock selected but still: nothing may arrive
    @(posedge ref_clk) ext_clk_select <= 1'b1;
    uee_remote_inst.send(8'h96, 0, 0, 1);
    repeat (6) @(posedge ref_clk) #1;
    check("ext still", {7'h00, rx_valid}, 8'h00);
    @(posedge ref_clk) ext_run <= 1'b1;
    uee_remote_inst.send(8'h69, 0, 0, 1);
    wait_rx();
    check("ext rx", rx_data, 8'h69);
    conclude();
  end
endmodule // tb
